// >>> evpu_pkg.sv
// Package with vector offsets, widths and reset values of the vector unit.
package evpu_pkg;
	localparam int          ADDR_W          = 24;
	localparam int          LVL_W           = 3;
	localparam int          TABLE_ENTRIES   = 128;
	localparam int          ENTRY_W         = 32;
	localparam int          ENTRY_BYTES     = 4;
	localparam int          ISR_LSB         = 0;
	localparam int          ISR_MSB         = 23;
	localparam logic [23:0] RESET_VECTOR    = 24'hfffffc;
	localparam logic [23:0] BASE_RESET      = 24'hfffe00;
	localparam logic [23:0] OFS_PAGE1_UNDEF = 24'h0001f8;
	localparam logic [23:0] OFS_PAGE2_UNDEF = 24'h0001f4;
	localparam logic [23:0] OFS_SW_TRAP     = 24'h0001f0;
	localparam logic [23:0] OFS_KERNEL_CALL = 24'h0001ec;
	localparam logic [23:0] OFS_MACHINE     = 24'h0001e8;
	localparam logic [23:0] OFS_RSVD1       = 24'h0001e4;
	localparam logic [23:0] OFS_RSVD0       = 24'h0001e0;
	localparam logic [23:0] OFS_SPURIOUS    = 24'h0001dc;
	localparam logic [23:0] OFS_NMI_PIN     = 24'h0001d8;
	localparam logic [23:0] OFS_IRQ_LINE    = 24'h0001d4;
	localparam logic [23:0] OFS_DEV_LO      = 24'h000010;
	localparam logic [23:0] OFS_DEV_HI      = 24'h0001d0;
	localparam int          DEV_CHANNELS    = 113;
	localparam logic [2:0]  LVL_FIXED       = 3'h7;
	localparam logic [2:0]  LVL_DISABLED    = 3'h0;
	localparam logic [2:0]  LVL_RESET       = 3'h1;
	localparam int          MAX_NEST        = 7;

	typedef enum logic [3:0] {
		evpu_src_none    = 4'h0,
		evpu_src_reset   = 4'h1,
		evpu_src_page1   = 4'h2,
		evpu_src_page2   = 4'h3,
		evpu_src_trap    = 4'h4,
		evpu_src_kcall   = 4'h5,
		evpu_src_machine = 4'h6,
		evpu_src_nmi     = 4'h7,
		evpu_src_irq     = 4'h8,
		evpu_src_dev     = 4'h9,
		evpu_src_spur    = 4'ha
	} evpu_src_t;
endpackage : evpu_pkg

// >>> evpu_prio_tree.sv
// Priority search over the device-specific maskable channels.
`timescale 1ns/1ps
`default_nettype none
module evpu_prio_tree #(
	parameter int N     = 113,
	parameter int LVL_W = 3,
	parameter int IDX_W = 7
) (
	input  wire logic [N-1:0]       req,
	input  wire logic [N*LVL_W-1:0] lvl,
	input  wire logic [LVL_W-1:0]   floor_lvl,
	output logic                    found,
	output logic [IDX_W-1:0]        win_idx,
	output logic [LVL_W-1:0]        win_lvl
);
	logic [N-1:0] elig;

	genvar g;
	generate
		for (g = 0; g < N; g++)
		begin : g_elig
			// Level zero disables a channel; only levels above the floor count.
			assign elig[g] = req[g] && (lvl[g*LVL_W +: LVL_W] > floor_lvl);
		end
	endgenerate

	// Ascending scan with >= lets the higher index win a tie, which is the
	// higher vector address because channel n sits at a higher offset.
	always_comb
	begin
		found   = 1'b0;
		win_idx = '0;
		win_lvl = '0;
		for (int i = 0; i < N; i++)
		begin
			if (elig[i] && (!found || lvl[i*LVL_W +: LVL_W] >= win_lvl))
			begin
				found   = 1'b1;
				win_idx = IDX_W'(i);
				win_lvl = lvl[i*LVL_W +: LVL_W];
			end
		end
	end
endmodule : evpu_prio_tree
`default_nettype wire

// >>> evpu_exception_vector_priority_unit.sv
// Exception ranking, vector supply and wake-up decision for the core.
`timescale 1ns/1ps
`default_nettype none
module evpu_exception_vector_priority_unit #(
	parameter int N_DEV = evpu_pkg::DEV_CHANNELS
) (
	input  wire logic                       ref_clk,
	input  wire logic                       srst,
	input  wire logic                       reset_cause,
	input  wire logic                       page1_undefined_opcode,
	input  wire logic                       page2_undefined_opcode,
	input  wire logic                       software_trap_instruction,
	input  wire logic                       kernel_call_instruction,
	input  wire logic                       machine_exception,
	input  wire logic                       nonmaskable_pin_request,
	input  wire logic                       interrupt_request_line,
	input  wire logic [N_DEV-1:0]           dev_request,
	input  wire logic [N_DEV*3-1:0]         channel_priority_level,
	input  wire logic [2:0]                 irq_line_level,
	input  wire logic                       maskable_disable_flag,
	input  wire logic                       pin_request_disable_flag,
	input  wire logic [2:0]                 current_processing_level,
	input  wire logic                       low_power_mode,
	input  wire logic                       base_write,
	input  wire logic [23:0]                base_wdata,
	input  wire logic                       vector_request,
	output logic                            vector_valid,
	output logic [23:0]                     vector_address,
	output logic [2:0]                      new_processing_level,
	output logic                            new_level_load,
	output logic                            handler_skip,
	output logic                            wake_core,
	output logic [23:0]                     vector_base,
	output logic                            pending_any
);
	localparam int IDX_W = $clog2(N_DEV);

	// Pin-side inputs come from outside this clock; pass them two flops.
	logic [1:0] nmi_sync;
	logic [1:0] irq_sync;
	logic [1:0] next_nmi_sync;
	logic [1:0] next_irq_sync;
	logic       nmi_s;
	logic       irq_s;

	always_comb
	begin
		next_nmi_sync = {nmi_sync[0], nonmaskable_pin_request};
		next_irq_sync = {irq_sync[0], interrupt_request_line};
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			nmi_sync <= 2'h0;
			irq_sync <= 2'h0;
		end
		else
		begin
			nmi_sync <= next_nmi_sync;
			irq_sync <= next_irq_sync;
		end
	end

	assign nmi_s = nmi_sync[1];
	assign irq_s = irq_sync[1];

	// Vector base register.
	logic [23:0] next_vector_base;

	always_comb
	begin
		next_vector_base = vector_base;
		if (base_write)
			next_vector_base = base_wdata;
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
			vector_base <= evpu_pkg::BASE_RESET;
		else
			vector_base <= next_vector_base;
	end

	// Maskable search over the device channels plus the request line.
	logic             dev_found;
	logic [IDX_W-1:0] dev_idx;
	logic [2:0]       dev_lvl;

	evpu_prio_tree #(
		.N     (N_DEV),
		.LVL_W (evpu_pkg::LVL_W),
		.IDX_W (IDX_W)
	) u_tree (
		.req       (dev_request),
		.lvl       (channel_priority_level),
		.floor_lvl (current_processing_level),
		.found     (dev_found),
		.win_idx   (dev_idx),
		.win_lvl   (dev_lvl)
	);

	logic irq_elig;
	logic mask_ok;
	logic irq_wins;
	logic mask_found;
	logic [2:0] mask_lvl;

	// The request line sits above all device channels, so it wins ties.
	assign irq_elig = irq_s && (irq_line_level > current_processing_level);
	assign irq_wins = irq_elig && (!dev_found || irq_line_level >= dev_lvl);
	assign mask_found = irq_elig || dev_found;
	assign mask_lvl = irq_wins ? irq_line_level : dev_lvl;
	// The mask flag gates preemption; the floor above keeps it strictly higher.
	assign mask_ok = mask_found && !maskable_disable_flag;

	// Ranking. Instruction exceptions are mutually exclusive, so a fixed
	// order among them costs nothing and adds no arbitration state.
	evpu_pkg::evpu_src_t sel;
	logic [23:0]         sel_ofs;

	always_comb
	begin
		sel     = evpu_pkg::evpu_src_spur;
		sel_ofs = evpu_pkg::OFS_SPURIOUS;
		if (reset_cause)
			sel = evpu_pkg::evpu_src_reset;
		else if (page1_undefined_opcode)
		begin
			sel     = evpu_pkg::evpu_src_page1;
			sel_ofs = evpu_pkg::OFS_PAGE1_UNDEF;
		end
		else if (page2_undefined_opcode)
		begin
			sel     = evpu_pkg::evpu_src_page2;
			sel_ofs = evpu_pkg::OFS_PAGE2_UNDEF;
		end
		else if (software_trap_instruction)
		begin
			sel     = evpu_pkg::evpu_src_trap;
			sel_ofs = evpu_pkg::OFS_SW_TRAP;
		end
		else if (kernel_call_instruction)
		begin
			sel     = evpu_pkg::evpu_src_kcall;
			sel_ofs = evpu_pkg::OFS_KERNEL_CALL;
		end
		else if (machine_exception)
		begin
			sel     = evpu_pkg::evpu_src_machine;
			sel_ofs = evpu_pkg::OFS_MACHINE;
		end
		else if (nmi_s && !pin_request_disable_flag)
		begin
			sel     = evpu_pkg::evpu_src_nmi;
			sel_ofs = evpu_pkg::OFS_NMI_PIN;
		end
		else if (mask_ok && irq_wins)
		begin
			sel     = evpu_pkg::evpu_src_irq;
			sel_ofs = evpu_pkg::OFS_IRQ_LINE;
		end
		else if (mask_ok)
		begin
			sel     = evpu_pkg::evpu_src_dev;
			// Each table entry is four bytes, so the channel index steps by 4.
			sel_ofs = evpu_pkg::OFS_DEV_LO + {15'h0000, dev_idx, 2'h0};
		end
	end

	// Vector answer registered one cycle after the request.
	logic        next_vector_valid;
	logic [23:0] next_vector_address;
	logic [2:0]  next_new_level;
	logic        next_level_load;

	always_comb
	begin
		next_vector_valid   = vector_request;
		next_vector_address = vector_address;
		next_new_level      = new_processing_level;
		next_level_load     = 1'b0;
		if (vector_request)
		begin
			if (sel == evpu_pkg::evpu_src_reset)
				next_vector_address = evpu_pkg::RESET_VECTOR;
			else
				next_vector_address = 24'(vector_base + sel_ofs);
			// Only routed maskable wins move the level; others leave it.
			if (sel == evpu_pkg::evpu_src_irq || sel == evpu_pkg::evpu_src_dev)
			begin
				next_new_level  = mask_lvl;
				next_level_load = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			vector_valid         <= 1'b0;
			vector_address       <= evpu_pkg::RESET_VECTOR;
			new_processing_level <= 3'h0;
			new_level_load       <= 1'b0;
		end
		else
		begin
			vector_valid         <= next_vector_valid;
			vector_address       <= next_vector_address;
			new_processing_level <= next_new_level;
			new_level_load       <= next_level_load;
		end
	end

	// Wake-up uses the run-mode maskable qualification; a disabled pin request still wakes, with handler_skip unless mask_ok or machine_exception.
	logic next_wake;
	logic next_skip;

	always_comb
	begin
		next_wake = low_power_mode &&
			(mask_ok || machine_exception || nmi_s);
		next_skip = low_power_mode && nmi_s && pin_request_disable_flag &&
			!mask_ok && !machine_exception;
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			wake_core    <= 1'b0;
			handler_skip <= 1'b0;
		end
		else
		begin
			wake_core    <= next_wake;
			handler_skip <= next_skip;
		end
	end

	assign pending_any = (sel != evpu_pkg::evpu_src_spur);

	AST_RESET_VEC: assert property (@(posedge ref_clk) disable iff (srst)
		vector_request && reset_cause |=> vector_address == 24'hfffffc)
		else $error("reset vector wrong");
	AST_TRAP_VEC: assert property (@(posedge ref_clk) disable iff (srst)
		vector_request && !reset_cause && software_trap_instruction &&
		!page1_undefined_opcode && !page2_undefined_opcode
		|=> vector_address == 24'($past(vector_base) + 24'h0001f0))
		else $error("trap vector wrong");
	AST_MACH_VEC: assert property (@(posedge ref_clk) disable iff (srst)
		sel == evpu_pkg::evpu_src_machine && vector_request
		|=> vector_address == 24'($past(vector_base) + 24'h0001e8))
		else $error("machine vector wrong");
	AST_NMI_OVER_MASK: assert property (@(posedge ref_clk) disable iff (srst)
		vector_request && nmi_s && !pin_request_disable_flag && !reset_cause &&
		!machine_exception && !software_trap_instruction &&
		!kernel_call_instruction && !page1_undefined_opcode &&
		!page2_undefined_opcode |=> !new_level_load)
		else $error("maskable beat pin request");
	AST_SPURIOUS: assert property (@(posedge ref_clk) disable iff (srst)
		vector_request && !pending_any && !reset_cause
		|=> vector_address == 24'($past(vector_base) + 24'h0001dc))
		else $error("spurious vector missing");
	AST_MASK_BLOCK: assert property (@(posedge ref_clk) disable iff (srst)
		maskable_disable_flag && vector_request |=> !new_level_load)
		else $error("masked request taken");
	AST_LEVEL_ABOVE: assert property (@(posedge ref_clk) disable iff (srst)
		vector_request ##1 new_level_load
		|-> new_processing_level > $past(current_processing_level))
		else $error("level not above current");
	AST_NMI_WAKE: assert property (@(posedge ref_clk) disable iff (srst)
		low_power_mode && nmi_s |=> wake_core)
		else $error("pin request did not wake");
	AST_MASK_NOWAKE: assert property (@(posedge ref_clk) disable iff (srst)
		low_power_mode && maskable_disable_flag && !nmi_s && !machine_exception
		|=> !wake_core)
		else $error("masked wake-up");
	AST_BASE_RST: assert property (@(posedge ref_clk)
		$past(srst) |-> vector_base == 24'hfffe00)
		else $error("base reset value wrong");

	COV_DEV: cover property (@(posedge ref_clk) disable iff (srst)
		vector_request ##1 new_level_load);
	COV_NMI: cover property (@(posedge ref_clk) disable iff (srst)
		sel == evpu_pkg::evpu_src_nmi && vector_request);
	COV_SKIP: cover property (@(posedge ref_clk) disable iff (srst)
		handler_skip);
	COV_SPUR: cover property (@(posedge ref_clk) disable iff (srst)
		vector_request && !pending_any);
endmodule : evpu_exception_vector_priority_unit
`default_nettype wire

// >>> evpu_core_model.sv
// Behavioural model of the core that fetches exception vectors.
`timescale 1ns/1ps
`default_nettype none
module evpu_core_model (
	input  wire logic        ref_clk,
	input  wire logic        vector_valid,
	input  wire logic [23:0] vector_address,
	input  wire logic [2:0]  new_processing_level,
	input  wire logic        new_level_load,
	output logic             vector_request
);
	initial vector_request = 1'b0;

	// Called just after a rising edge; the answer is taken one edge later.
	task automatic fetch(output logic [23:0] a, output logic [2:0] l,
		output logic ld, output logic v);
		vector_request = 1'b1;
		@(posedge ref_clk);
		#1;
		vector_request = 1'b0;
		// Only the low 24 bits of an entry are ever used as a handler.
		a = vector_address[23:0];
		l = new_processing_level;
		ld = new_level_load;
		v = vector_valid;
	endtask : fetch
endmodule : evpu_core_model
`default_nettype wire

// >>> tb_exception_vector_priority_unit.sv
// Self-checking testbench for the exception vector priority unit.
`timescale 1ns/1ps
`default_nettype none
module tb_exception_vector_priority_unit;
	localparam int N = 113;
	logic           ref_clk, srst, mdf, xdf, lpm, bwr, vreq;
	logic [7:0]     src;
	logic [N-1:0]   dreq;
	logic [N*3-1:0] lvl;
	logic [2:0]     irql, cpl, nlvl;
	logic [23:0]    bwd, vaddr, vbase;
	logic           vvalid, nload, skip, wake, pend;
	int             miscompares = 0;
	int             check_count = 0;

	evpu_exception_vector_priority_unit #(.N_DEV(N)) dut (
		.ref_clk(ref_clk), .srst(srst), .reset_cause(src[7]),
		.page1_undefined_opcode(src[6]), .page2_undefined_opcode(src[5]),
		.software_trap_instruction(src[4]),
		.kernel_call_instruction(src[3]), .machine_exception(src[2]),
		.nonmaskable_pin_request(src[1]), .interrupt_request_line(src[0]),
		.dev_request(dreq), .channel_priority_level(lvl),
		.irq_line_level(irql), .maskable_disable_flag(mdf),
		.pin_request_disable_flag(xdf), .current_processing_level(cpl),
		.low_power_mode(lpm), .base_write(bwr), .base_wdata(bwd),
		.vector_request(vreq), .vector_valid(vvalid),
		.vector_address(vaddr), .new_processing_level(nlvl),
		.new_level_load(nload), .handler_skip(skip), .wake_core(wake),
		.vector_base(vbase), .pending_any(pend)
	);

	evpu_core_model core (
		.ref_clk(ref_clk), .vector_valid(vvalid), .vector_address(vaddr),
		.new_processing_level(nlvl), .new_level_load(nload),
		.vector_request(vreq)
	);

	initial
	begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : step

	task automatic chk(input string nm, input logic [23:0] got, exp);
		check_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[FAIL] %s exp %h got %h", nm, exp, got);
		end
	endtask : chk

	task automatic fetch_chk(input string nm, input logic [23:0] ea,
		input logic [2:0] el, input logic eld);
		logic [23:0] a;
		logic [2:0]  l;
		logic        ld, v;
		core.fetch(a, l, ld, v);
		chk({nm, " valid"}, 24'(v), 24'h1);
		chk(nm, a, ea);
		chk({nm, " load"}, 24'(ld), 24'(eld));
		if (eld)
			chk({nm, " level"}, 24'(l), 24'(el));
	endtask : fetch_chk

	task automatic print_verdict();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : print_verdict

	task automatic t_reset();
		chk("addr", vaddr, 24'hfffffc);
		chk("base", vbase, 24'hfffe00);
		chk("valid", 24'(vvalid), 24'h0);
		chk("wake", 24'(wake), 24'h0);
		chk("skip", 24'(skip), 24'h0);
		$display("test reset done");
	endtask : t_reset

	// Only one instruction exception is raised at a time.
	task automatic t_ladder();
		logic [7:0]  s [9];
		logic [23:0] e [9];
		s = '{8'hc7, 8'h47, 8'h27, 8'h17, 8'h0f, 8'h07, 8'h03, 8'h01, 8'h00};
		e = '{24'hfffffc, 24'hfffff8, 24'hfffff4, 24'hfffff0, 24'hffffec,
			24'hffffe8, 24'hffffd8, 24'hffffd4, 24'hffffdc};
		lvl = {N{3'h1}};
		mdf = 1'b0;
		xdf = 1'b0;
		for (int i = 0; i < 9; i++)
		begin
			src = s[i];
			step(3);
			chk("ladder pend", 24'(pend), 24'(i != 8));
			fetch_chk("ladder", e[i], 3'h1, i == 7);
		end
		$display("test ladder done");
	endtask : t_ladder

	task automatic t_dev();
		lvl = '0;
		lvl[2:0] = 3'h3;
		lvl[17:15] = 3'h3;
		dreq[0] = 1'b1;
		dreq[5] = 1'b1;
		step(1);
		fetch_chk("tie", 24'hfffe24, 3'h3, 1'b1);
		lvl[2:0] = 3'h4;
		step(1);
		fetch_chk("level", 24'hfffe10, 3'h4, 1'b1);
		cpl = 3'h3;
		step(1);
		fetch_chk("nest", 24'hfffe10, 3'h4, 1'b1);
		cpl = 3'h4;
		step(1);
		fetch_chk("below", 24'hffffdc, 3'h0, 1'b0);
		cpl = 3'h0;
		mdf = 1'b1;
		step(1);
		fetch_chk("masked", 24'hffffdc, 3'h0, 1'b0);
		mdf = 1'b0;
		dreq = '0;
		dreq[N-1] = 1'b1;
		step(1);
		fetch_chk("off", 24'hffffdc, 3'h0, 1'b0);
		// The request line sits above every channel, so it wins a level tie.
		dreq[0] = 1'b1;
		irql = 3'h4;
		src = 8'h01;
		step(3);
		fetch_chk("line tie", 24'hffffd4, 3'h4, 1'b1);
		irql = 3'h3;
		step(1);
		fetch_chk("line low", 24'hfffe10, 3'h4, 1'b1);
		src = 8'h00;
		step(3);
		$display("test device done");
	endtask : t_dev

	task automatic t_wake();
		lpm = 1'b1;
		dreq = '0;
		dreq[0] = 1'b1;
		step(2);
		chk("wake dev", 24'(wake), 24'h1);
		chk("skip dev", 24'(skip), 24'h0);
		mdf = 1'b1;
		step(2);
		chk("wake masked", 24'(wake), 24'h0);
		mdf = 1'b0;
		cpl = 3'h4;
		step(2);
		chk("wake low", 24'(wake), 24'h0);
		dreq = '0;
		src = 8'h04;
		step(2);
		chk("wake mach", 24'(wake), 24'h1);
		// The pin stays high until execution has resumed.
		xdf = 1'b1;
		src = 8'h02;
		step(4);
		chk("wake pin", 24'(wake), 24'h1);
		chk("skip pin", 24'(skip), 24'h1);
		fetch_chk("pin x", 24'hffffdc, 3'h0, 1'b0);
		src = 8'h00;
		xdf = 1'b0;
		lpm = 1'b0;
		cpl = 3'h0;
		step(3);
		$display("test wake done");
	endtask : t_wake

	task automatic t_base();
		bwr = 1'b1;
		bwd = 24'hffff00;
		step(1);
		bwr = 1'b0;
		chk("base new", vbase, 24'hffff00);
		src = 8'h10;
		step(1);
		fetch_chk("wrap", 24'h0000f0, 3'h0, 1'b0);
		src = 8'h00;
		srst = 1'b1;
		step(1);
		srst = 1'b0;
		step(1);
		chk("base rst", vbase, 24'hfffe00);
		chk("addr rst", vaddr, 24'hfffffc);
		$display("test base done");
	endtask : t_base

	initial
	begin
		srst = 1'b1;
		src = 8'h00;
		dreq = '0;
		lvl = '0;
		irql = 3'h1;
		cpl = 3'h0;
		mdf = 1'b1;
		xdf = 1'b1;
		lpm = 1'b0;
		bwr = 1'b0;
		bwd = 24'h000000;
		step(4);
		srst = 1'b0;
		step(1);
		t_reset();
		t_ladder();
		t_dev();
		t_wake();
		t_base();
		print_verdict();
	end

	// Cuts a hang short; the tests need fewer than a hundred cycles.
	initial
	begin
		repeat (3000) @(posedge ref_clk);
		miscompares++;
		print_verdict();
	end
endmodule : tb_exception_vector_priority_unit
`default_nettype wire
